// >>> verilog/chp_pkg.sv
// Constants, register map and types of the charger host register port
package chp_pkg;
    // Target address D6h in 8-bit form, 6Bh as 7 bits
    localparam logic [6:0] TGT_ADDR = 7'h6B;
    // Byte addresses of the low byte of each word
    localparam logic [7:0] A_OPT0 = 8'h00;
    localparam logic [7:0] A_CHG = 8'h02;
    localparam logic [7:0] A_MCV = 8'h04;
    localparam logic [7:0] A_ROV = 8'h06;
    localparam logic [7:0] A_IIN = 8'h08;
    localparam logic [7:0] A_VIN = 8'h0A;
    localparam logic [7:0] A_STAT = 8'h20;
    localparam logic [7:0] A_HOT = 8'h22;
    localparam logic [7:0] A_OPT1 = 8'h30;
    localparam logic [7:0] A_OPT2 = 8'h32;
    localparam logic [7:0] A_OPT3 = 8'h34;
    localparam logic [7:0] A_HOT0 = 8'h36;
    localparam logic [7:0] A_HOT1 = 8'h38;
    localparam logic [7:0] A_ADC = 8'h3A;
    // Word indices of the writable words
    localparam logic [3:0] I_OPT0 = 4'h0;
    localparam logic [3:0] I_CHG = 4'h1;
    localparam logic [3:0] I_MCV = 4'h2;
    localparam logic [3:0] I_ROV = 4'h3;
    localparam logic [3:0] I_IIN = 4'h4;
    localparam logic [3:0] I_VIN = 4'h5;
    localparam logic [3:0] I_OPT1 = 4'h6;
    localparam logic [3:0] I_OPT2 = 4'h7;
    localparam logic [3:0] I_OPT3 = 4'h8;
    localparam logic [3:0] I_HOT0 = 4'h9;
    localparam logic [3:0] I_HOT1 = 4'hA;
    localparam logic [3:0] I_ADC = 4'hB;
    localparam logic [3:0] NUM_W = 4'hC;
    // Reset values
    localparam logic [15:0] RST_OPT0 = 16'hE70E;
    localparam logic [15:0] RST_SET = 16'h0000;
    localparam logic [15:0] RST_OPT1 = 16'h0211;
    localparam logic [15:0] RST_OPT2 = 16'h02B7;
    localparam logic [15:0] RST_OPT3 = 16'h0030;
    localparam logic [15:0] RST_HOT0 = 16'h4A65;
    localparam logic [15:0] RST_HOT1 = 16'h81A0;
    localparam logic [15:0] RST_ADC = 16'h2000;
    localparam logic [15:0] RST_HOTST = 16'hA800;
    // Field positions
    localparam int LOWPWR_BIT = 15;
    localparam int ADC_EN_BIT = 14;
    localparam int THR_LSB = 10;
    localparam int THR_W = 6;
    localparam int DCHG_FLAG = 3;
    localparam int THR_STEP_SHIFT = 9;
    localparam logic [16:0] THR_OFS_MA = 17'h00080;
    // Two-byte watchdog
    localparam int unsigned PAIR_WDOG_MS = 5000;
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned PAIR_WDOG_CYC = PAIR_WDOG_MS * CLK_KHZ;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_AACK = 4'b0011,
        ST_REG = 4'b0010,
        ST_RACK = 4'b0110,
        ST_WR = 4'b0111,
        ST_WACK = 4'b0101,
        ST_RD = 4'b0100,
        ST_RDACK = 4'b1100
    } chp_state_type;
    typedef enum logic [2:0] {
        CH_BAT, CH_SYS, CH_CHG, CH_DCHG, CH_IIN, CH_SYSTEM_POWER_CHANNEL, CH_BUS, CH_CMP
    } chp_chan_type;
endpackage

// >>> verilog/chp_port.sv
// I2C register port, option and alert registers, converter sequencing
`timescale 1ns/10ps
// Summary of operation
// - Undefined register address gets NACK and the port returns to idle.
// - Several data bytes per transaction are accepted on writes and reads.
// - Five settings are each two byte registers forming one value.
// - Both bytes of a setting update together after the high byte.
// - A high byte without a prior low byte is discarded.
// - Low and high byte too far apart in time are both discarded.
// - Disabled alert sources no longer set their alert status flag.
// - Disabled alert sources no longer pull the alert pin low.
// - Discharge alert fires above threshold of 512 mA steps plus 128 mA.
// - Converter channels run battery, system, charge, discharge, input on.
// - Converter stays off while the device is in low power mode.
// - Enabling the converter on battery only leaves low power mode.
// - Target answers at address D6h, standard and fast mode.
// - Seven bit address plus direction bit, zero write, one read.
module chp_port
    import chp_pkg::*;
#(
    parameter int unsigned WDOG_CYC = PAIR_WDOG_CYC
) (
    input wire logic sys_clk_in, // 100 MHz clock
    input wire logic nrst_in, // Synchronous reset, active low
    input wire logic scl_in, // Bus clock pin level
    input wire logic sda_in, // Bus data pin level
    output logic sda_oe_n_out, // Low pulls data line low
    input wire logic [15:0] charger_status_in, // Status word bits
    input wire logic [7:0] alert_events_in, // Raw alert sources
    input wire logic [15:0] discharge_ma_in, // Discharge current, mA
    input wire logic battery_only_in, // No adapter present
    input wire logic converter_done_in, // Channel conversion done
    output logic converter_enable_out, // Converter running
    output logic [2:0] converter_channel_out, // Channel now converted
    output logic processor_hot_alert_oe_n_out, // Low pulls alert low
    output logic low_power_out, // Low power mode
    output logic [15:0] charge_current_setting_out, // Setting
    output logic [15:0] max_charge_voltage_setting_out, // Setting
    output logic [15:0] input_current_limit_setting_out, // Setting
    output logic [15:0] reverse_output_voltage_setting_out, // Setting
    output logic [15:0] input_voltage_setting_out // Setting
);
    localparam int SW = 27;
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic [1:0] s3_q;
    logic scl_s;
    logic sda_s;
    logic batt_s;
    logic [15:0] stat_s;
    logic [7:0] ev_s;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    chp_state_type st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] ptr_q, ptr_d;
    logic rw_q, rw_d;
    logic oe_q, oe_d;
    logic wr_en;
    logic rd_clr;

    logic [15:0] regs_q [NUM_W];
    logic [15:0] regs_d [NUM_W];
    logic [7:0] lo_q, lo_d;
    logic [3:0] pidx_q, pidx_d;
    logic pend_q, pend_d;
    logic [31:0] wd_q, wd_d;
    logic [7:0] hot_q, hot_d;
    logic alert_q, alert_d;
    logic cen_q, cen_d;
    chp_chan_type ch_q, ch_d;
    logic [7:0] ev;
    logic dchg_hit;

    // Two flops before any reader of bus, battery, status and alert pins; edges look at stages two and three only
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            // Bus pins idle high, other inputs low: no false alert
            s1_q <= {2'b11, {(SW-2){1'b0}}};
            s2_q <= {2'b11, {(SW-2){1'b0}}};
            s3_q <= 2'b11;
        end else begin
            s1_q <= {scl_in, sda_in, battery_only_in, charger_status_in,
                     alert_events_in};
            s2_q <= s1_q;
            s3_q <= s2_q[SW-1:SW-2];
        end
    end

    assign scl_s = s2_q[SW-1];
    assign sda_s = s2_q[SW-2];
    assign batt_s = s2_q[SW-3];
    assign stat_s = s2_q[23:8];
    assign ev_s = s2_q[7:0];
    assign rise = scl_s & ~s3_q[1];
    assign fall = ~scl_s & s3_q[1];
    assign start = scl_s & s3_q[1] & ~sda_s & s3_q[0];
    assign stop = scl_s & s3_q[1] & sda_s & ~s3_q[0];

    function automatic logic [3:0] widx(input logic [7:0] a);
        case (a & 8'hFE)
            A_OPT0: widx = I_OPT0;
            A_CHG: widx = I_CHG;
            A_MCV: widx = I_MCV;
            A_ROV: widx = I_ROV;
            A_IIN: widx = I_IIN;
            A_VIN: widx = I_VIN;
            A_OPT1: widx = I_OPT1;
            A_OPT2: widx = I_OPT2;
            A_OPT3: widx = I_OPT3;
            A_HOT0: widx = I_HOT0;
            A_HOT1: widx = I_HOT1;
            A_ADC: widx = I_ADC;
            default: widx = NUM_W;
        endcase
    endfunction

    function automatic logic is_ro(input logic [7:0] a);
        is_ro = ((a & 8'hFE) == A_STAT) || ((a & 8'hFE) == A_HOT);
    endfunction

    function automatic logic is_pair(input logic [3:0] i);
        is_pair = (i >= I_CHG) && (i <= I_VIN);
    endfunction

    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [15:0] w;
        w = 16'h0000;
        if (widx(a) != NUM_W)
            w = regs_q[widx(a)];
        else if ((a & 8'hFE) == A_STAT)
            w = stat_s;
        else if ((a & 8'hFE) == A_HOT)
            w = {RST_HOTST[15:8], hot_q};
        rd_byte = a[0] ? w[15:8] : w[7:0];
    endfunction

    // Bus target state machine
    always_comb begin
        logic [7:0] rd_b;
        rd_b = rd_byte(ptr_q);
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        oe_d = oe_q;
        wr_en = 1'b0;
        rd_clr = 1'b0;
        if (start) begin
            st_d = ST_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b1;
        end else if (stop) begin
            st_d = ST_IDLE;
            oe_d = 1'b1;
        end else begin
            case (st_q)
                ST_ADDR, ST_REG, ST_WR: begin
                    if (rise) begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall && cnt_q == BYTE_BITS) begin
                        cnt_d = 4'h0;
                        oe_d = 1'b0;
                        if (st_q == ST_ADDR) begin
                            rw_d = sh_q[0];
                            st_d = ST_AACK;
                            if (sh_q[7:1] != TGT_ADDR) begin
                                oe_d = 1'b1;
                                st_d = ST_IDLE;
                            end
                        end else if (st_q == ST_REG) begin
                            ptr_d = sh_q;
                            st_d = ST_RACK;
                            if (widx(sh_q) == NUM_W && !is_ro(sh_q)) begin
                                oe_d = 1'b1;
                                st_d = ST_IDLE;
                            end
                        end else if (widx(ptr_q) == NUM_W && !is_ro(ptr_q))
                        begin
                            oe_d = 1'b1;
                            st_d = ST_IDLE;
                        end else begin
                            wr_en = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                            st_d = ST_WACK;
                        end
                    end
                end
                ST_AACK, ST_RACK, ST_WACK: begin
                    if (fall) begin
                        oe_d = 1'b1;
                        st_d = (st_q == ST_AACK) ? ST_REG : ST_WR;
                        if (st_q == ST_AACK && rw_q) begin
                            sh_d = {rd_b[6:0], 1'b0};
                            oe_d = rd_b[7];
                            rd_clr = ((ptr_q & 8'hFE) == A_HOT);
                            ptr_d = ptr_q + 8'h01;
                            cnt_d = 4'h1;
                            st_d = ST_RD;
                        end
                    end
                end
                ST_RD: begin
                    if (fall) begin
                        if (cnt_q == BYTE_BITS) begin
                            oe_d = 1'b1;
                            st_d = ST_RDACK;
                        end else begin
                            oe_d = sh_q[7];
                            sh_d = {sh_q[6:0], 1'b0};
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                ST_RDACK: begin
                    if (rise && sda_s) begin
                        st_d = ST_IDLE;
                    end else if (fall) begin
                        // Multi-byte read continues on the next byte
                        sh_d = {rd_b[6:0], 1'b0};
                        oe_d = rd_b[7];
                        rd_clr = ((ptr_q & 8'hFE) == A_HOT);
                        ptr_d = ptr_q + 8'h01;
                        cnt_d = 4'h1;
                        st_d = ST_RD;
                    end
                end
                default: begin
                    oe_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            oe_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
        end
    end

    // Discharge alert compare; threshold is sign-free, 17 bits wide
    assign dchg_hit = {1'b0, discharge_ma_in} >
        (({11'h000, regs_q[I_HOT1][THR_LSB +: THR_W]} << THR_STEP_SHIFT)
         + THR_OFS_MA);
    always_comb begin
        ev = ev_s;
        ev[DCHG_FLAG] = dchg_hit;
        ev = ev & regs_q[I_HOT1][7:0];
    end

    // Register file, two-byte staging, alert and converter control
    always_comb begin
        logic [3:0] wi;
        wi = widx(ptr_q);
        regs_d = regs_q;
        lo_d = lo_q;
        pidx_d = pidx_q;
        pend_d = pend_q;
        wd_d = pend_q ? wd_q + 32'h1 : 32'h0;
        if (pend_q && wd_q >= WDOG_CYC - 1)
            pend_d = 1'b0;
        // A new event wins over the clear by read
        hot_d = (rd_clr ? 8'h00 : hot_q) | ev;
        if (wr_en && wi != NUM_W) begin
            pend_d = 1'b0;
            if (is_pair(wi)) begin
                if (!ptr_q[0]) begin
                    lo_d = sh_q;
                    pidx_d = wi;
                    pend_d = 1'b1;
                    wd_d = 32'h0;
                end else if (pend_q && pidx_q == wi
                             && wd_q < WDOG_CYC - 1) begin
                    regs_d[wi] = {sh_q, lo_q};
                end
            end else if (ptr_q[0]) begin
                regs_d[wi][15:8] = sh_q;
            end else begin
                regs_d[wi][7:0] = sh_q;
            end
            if (wi == I_ADC && regs_d[I_ADC][ADC_EN_BIT] && batt_s)
                regs_d[I_OPT0][LOWPWR_BIT] = 1'b0;
        end else if (wr_en) begin
            pend_d = 1'b0;
        end
        alert_d = ~|ev;
        cen_d = regs_q[I_ADC][ADC_EN_BIT]
            & ~regs_q[I_OPT0][LOWPWR_BIT];
        ch_d = ch_q;
        if (!cen_q)
            ch_d = CH_BAT;
        else if (converter_done_in)
            ch_d = chp_chan_type'(ch_q + 3'h1);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            regs_q[I_OPT0] <= RST_OPT0;
            regs_q[I_CHG] <= RST_SET;
            regs_q[I_MCV] <= RST_SET;
            regs_q[I_ROV] <= RST_SET;
            regs_q[I_IIN] <= RST_SET;
            regs_q[I_VIN] <= RST_SET;
            regs_q[I_OPT1] <= RST_OPT1;
            regs_q[I_OPT2] <= RST_OPT2;
            regs_q[I_OPT3] <= RST_OPT3;
            regs_q[I_HOT0] <= RST_HOT0;
            regs_q[I_HOT1] <= RST_HOT1;
            regs_q[I_ADC] <= RST_ADC;
            lo_q <= 8'h00;
            pidx_q <= I_OPT0;
            pend_q <= 1'b0;
            wd_q <= 32'h0;
            hot_q <= RST_HOTST[7:0];
            alert_q <= 1'b1;
            cen_q <= 1'b0;
            ch_q <= CH_BAT;
        end else begin
            regs_q <= regs_d;
            lo_q <= lo_d;
            pidx_q <= pidx_d;
            pend_q <= pend_d;
            wd_q <= wd_d;
            hot_q <= hot_d;
            alert_q <= alert_d;
            cen_q <= cen_d;
            ch_q <= ch_d;
        end
    end

    assign sda_oe_n_out = oe_q;
    assign processor_hot_alert_oe_n_out = alert_q;
    assign converter_enable_out = cen_q;
    assign converter_channel_out = ch_q;
    assign low_power_out = regs_q[I_OPT0][LOWPWR_BIT];
    assign charge_current_setting_out = regs_q[I_CHG];
    assign max_charge_voltage_setting_out = regs_q[I_MCV];
    assign input_current_limit_setting_out = regs_q[I_IIN];
    assign reverse_output_voltage_setting_out = regs_q[I_ROV];
    assign input_voltage_setting_out = regs_q[I_VIN];
endmodule

// >>> verification/chp_port_chk.sv
// Port level checker of the charger host register port
`timescale 1ns/10ps
module chp_port_chk #(
    parameter int unsigned WDOG_CYC = 200
) (
    input wire logic sys_clk_in, // Clock
    input wire logic nrst_in, // Reset, active low
    input wire logic scl_in, // Bus clock
    input wire logic sda_oe_n_out, // Data pull
    input wire logic [7:0] alert_events_in, // Alert sources
    input wire logic [15:0] discharge_ma_in, // Discharge current
    input wire logic converter_done_in, // Conversion done
    input wire logic converter_enable_out, // Converter on
    input wire logic [2:0] converter_channel_out, // Channel
    input wire logic processor_hot_alert_oe_n_out, // Alert pull
    input wire logic low_power_out, // Low power
    input wire logic [15:0] charge_current_setting_out // Setting
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);
    chk_reset_vals: assert property ($rose(nrst_in) |-> sda_oe_n_out &&
        processor_hot_alert_oe_n_out && low_power_out &&
        !converter_enable_out && converter_channel_out == 3'h0 &&
        charge_current_setting_out == 16'h0000)
        else $error("outputs not at reset values");
    chk_lowpwr_off: assert property (low_power_out |=>
        !converter_enable_out)
        else $error("converter running in low power");
    chk_chan_idle: assert property (!converter_enable_out [*2] |->
        converter_channel_out == 3'h0)
        else $error("channel not zero while off");
    chk_chan_step: assert property (converter_enable_out &&
        converter_done_in ##1 converter_enable_out |->
        converter_channel_out == $past(converter_channel_out) + 3'h1)
        else $error("channel did not advance by one");
    chk_chan_hold: assert property (converter_enable_out &&
        !converter_done_in ##1 converter_enable_out |->
        $stable(converter_channel_out))
        else $error("channel moved without done");
    chk_alert_quiet: assert property ((alert_events_in == 8'h00 &&
        discharge_ma_in == 16'h0000) [*4] |=> processor_hot_alert_oe_n_out)
        else $error("alert pulled without event");
    chk_sda_hold: assert property (scl_in [*8] |->
        $stable(sda_oe_n_out))
        else $error("data pull changed while clock high");
    chk_set_ack: assert property ($changed(charge_current_setting_out)
        |-> !scl_in && !sda_oe_n_out)
        else $error("setting changed outside acknowledge");
    cov_step: cover property (converter_enable_out && converter_done_in);
    cov_set: cover property ($changed(charge_current_setting_out));
    cov_alert: cover property ($fell(processor_hot_alert_oe_n_out));
endmodule

// >>> verification/chp_hm.sv
// Bus master model standing in for the host controller
`timescale 1ns/10ps
module chp_hm (
    input wire logic clk_in, // Bench clock
    input wire logic sda_oe_n_in, // Target pulls data low
    output logic scl_out, // Bus clock level
    output logic sda_out // Data level on the wire
);
    logic sda_m = 1'b1;
    initial scl_out = 1'b1;
    // Pull-up: a released line reads high
    assign sda_out = sda_m & sda_oe_n_in;
    task automatic hp();
        repeat (6) @(negedge clk_in);
    endtask
    task automatic start();
        sda_m = 1'b1;
        hp();
        scl_out = 1'b1;
        hp();
        sda_m = 1'b0;
        hp();
        scl_out = 1'b0;
        hp();
    endtask
    task automatic stop();
        sda_m = 1'b0;
        hp();
        scl_out = 1'b1;
        hp();
        sda_m = 1'b1;
        hp();
    endtask
    // Data only moves with the clock low
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        hp();
        scl_out = 1'b1;
        hp();
        r = sda_out;
        scl_out = 1'b0;
        hp();
    endtask
    task automatic wb(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rb(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!mack, r);
    endtask
endmodule

// >>> verification/chp_port_tb.sv
// Self-checking bench of the charger host register port
`timescale 1ns/10ps
module chp_port_tb;
    import chp_pkg::*;
    localparam int unsigned WD = 2000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic scl, sda, sda_oe, en, lp, hot, ok;
    logic done = 1'b0;
    logic bat = 1'b0;
    logic [15:0] st = 16'h0000;
    logic [15:0] dma = 16'h0000;
    logic [7:0] ev = 8'h00;
    logic [2:0] ch;
    logic [5:0] thr;
    logic [15:0] so [5];
    logic [15:0] ex [5];
    logic [7:0] rm [64];
    logic [7:0] q [$];
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    int lim;
    always #5 clk = ~clk;
    chp_hm chp_hm_i (.clk_in(clk), .sda_oe_n_in(sda_oe), .scl_out(scl),
        .sda_out(sda));
    chp_port #(.WDOG_CYC(WD)) chp_port_i (.sys_clk_in(clk), .nrst_in(nrst),
        .scl_in(scl), .sda_in(sda), .sda_oe_n_out(sda_oe),
        .charger_status_in(st), .alert_events_in(ev),
        .discharge_ma_in(dma), .battery_only_in(bat),
        .converter_done_in(done), .converter_enable_out(en),
        .converter_channel_out(ch), .processor_hot_alert_oe_n_out(hot),
        .low_power_out(lp), .charge_current_setting_out(so[0]),
        .max_charge_voltage_setting_out(so[1]),
        .reverse_output_voltage_setting_out(so[2]),
        .input_current_limit_setting_out(so[3]),
        .input_voltage_setting_out(so[4]));
    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [15:0] e,
            input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d [$],
            input logic u);
        logic k;
        chp_hm_i.start();
        chp_hm_i.wb({TGT_ADDR, 1'b0}, ok);
        chp_hm_i.wb(a, k);
        ok &= k;
        foreach (d[i]) begin
            chp_hm_i.wb(d[i], k);
            ok &= k;
            if (u) begin
                rm[a + i] = d[i];
            end
        end
        chp_hm_i.stop();
    endtask
    task automatic rchk(input logic [7:0] a, input int n);
        logic k;
        logic [7:0] b;
        chp_hm_i.start();
        chp_hm_i.wb({TGT_ADDR, 1'b0}, k);
        chp_hm_i.wb(a, k);
        chp_hm_i.start();
        chp_hm_i.wb({TGT_ADDR, 1'b1}, k);
        for (int i = 0; i < n; i++) begin
            chp_hm_i.rb(i < n - 1, b);
            cmp("read byte", {8'h00, rm[a + i]}, {8'h00, b});
        end
        chp_hm_i.stop();
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(23567));
        st = 16'($urandom);
        foreach (rm[i]) rm[i] = 8'h00;
        {rm[1], rm[0]} = RST_OPT0;
        {rm[8'h21], rm[8'h20]} = st;
        {rm[8'h23], rm[8'h22]} = RST_HOTST;
        {rm[8'h31], rm[8'h30]} = RST_OPT1;
        {rm[8'h33], rm[8'h32]} = RST_OPT2;
        {rm[8'h35], rm[8'h34]} = RST_OPT3;
        {rm[8'h37], rm[8'h36]} = RST_HOT0;
        {rm[8'h39], rm[8'h38]} = RST_HOT1;
        {rm[8'h3B], rm[8'h3A]} = RST_ADC;
        foreach (ex[i]) ex[i] = RST_SET;
        w(16);
        nrst = 1'b1;
        w(4);
        rchk(8'h00, 12);
        rchk(8'h20, 4);
        rchk(8'h30, 12);
        chp_hm_i.start();
        chp_hm_i.wb({TGT_ADDR ^ 7'h01, 1'b0}, ok);
        chp_hm_i.stop();
        cmp("foreign address ack", 16'h0000, {15'h0, ok});
        wr(8'h0C + 8'($urandom % 20), '{8'h55}, 1'b0);
        cmp("undefined reg ack", 16'h0000, {15'h0, ok});
        repeat (8) q.push_back(8'($urandom));
        wr(8'h30, q, 1'b1);
        cmp("multi write ack", 16'h0001, {15'h0, ok});
        rchk(8'h30, 8);
        for (int k = 0; k < 5; k++) begin
            logic [7:0] a;
            logic [15:0] v;
            a = 8'(2 + 2 * k);
            v = 16'($urandom);
            wr(a, '{v[7:0]}, 1'b0);
            cmp("setting after low", ex[k], so[k]);
            wr(a + 8'h01, '{v[15:8]}, 1'b0);
            ex[k] = v;
            {rm[a + 1], rm[a]} = v;
            cmp("setting pair", ex[k], so[k]);
            wr(a + 8'h01, '{~v[15:8]}, 1'b0);
            cmp("high only", ex[k], so[k]);
            wr(a, '{~v[7:0]}, 1'b0);
            w(WD + 10);
            wr(a + 8'h01, '{~v[15:8]}, 1'b0);
            cmp("late high", ex[k], so[k]);
        end
        rchk(8'h02, 10);
        ev = 8'h01;
        w(6);
        cmp("alert pin masked", 16'h0001, {15'h0, hot});
        ev = 8'h00;
        rchk(8'h22, 1);
        wr(8'h38, '{8'hA1}, 1'b1);
        ev = 8'h01;
        w(6);
        cmp("alert pin enabled", 16'h0000, {15'h0, hot});
        ev = 8'h00;
        w(6);
        cmp("alert pin released", 16'h0001, {15'h0, hot});
        rm[8'h22] = 8'h01;
        rchk(8'h22, 1);
        rm[8'h22] = 8'h00;
        rchk(8'h22, 1);
        thr = 6'($urandom);
        lim = thr * 512 + 128;
        wr(8'h38, '{8'h08, {thr, 2'b01}}, 1'b1);
        dma = 16'(lim);
        w(6);
        cmp("discharge at limit", 16'h0001, {15'h0, hot});
        dma = 16'(lim + 1);
        w(6);
        cmp("discharge above limit", 16'h0000, {15'h0, hot});
        dma = 16'h0000;
        cmp("converter off", 16'h0000, {15'h0, en});
        wr(8'h3B, '{8'h40}, 1'b1);
        cmp("low power kept", 16'h0001, {15'h0, lp});
        bat = 1'b1;
        w(4);
        wr(8'h3B, '{8'h40}, 1'b1);
        rm[1] = rm[1] & 8'h7F;
        w(2);
        cmp("low power left", 16'h0000, {15'h0, lp});
        cmp("converter on", 16'h0001, {15'h0, en});
        for (int i = 0; i < 9; i++) begin
            cmp("channel", 16'(i % 8), {13'h0, ch});
            done = 1'b1;
            w(1);
            done = 1'b0;
            w(2);
        end
        wr(8'h01, '{rm[1] | 8'h80}, 1'b1);
        w(2);
        cmp("converter off again", 16'h0000, {15'h0, en});
        cmp("channel reset", 16'h0000, {13'h0, ch});
        rchk(8'h00, 2);
        rchk(8'h30, 12);
        complete_run();
    end
endmodule
bind chp_port chp_port_chk #(.WDOG_CYC(WDOG_CYC)) chp_port_chk_i (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .scl_in(scl_in),
    .sda_oe_n_out(sda_oe_n_out), .alert_events_in(alert_events_in),
    .discharge_ma_in(discharge_ma_in), .converter_done_in(converter_done_in),
    .converter_enable_out(converter_enable_out),
    .converter_channel_out(converter_channel_out),
    .processor_hot_alert_oe_n_out(processor_hot_alert_oe_n_out),
    .low_power_out(low_power_out),
    .charge_current_setting_out(charge_current_setting_out));
